// File: sync_channel_port_config.v
// configuration registers of sync clock channels 5, 6 and 7
// assumes a classic wishbone master on the same clock; tdc use flags and
// shared divider ratios come from logic on the same clock
// Functional notes
// R1: bit7 of first picks divider A or B
// R2: bit6 sets drive current, 0 low, 1 high
// R3: bits5:0 hold common-mode resistor code
// R4: current bit scales common-mode voltage too
// R5: bit7 of second enables receiver auto powerdown
// R6: software sets auto powerdown after reset
// R7: bit5 disconnects receiver float terminations
// R8: bit4 disconnects driver float terminations
// R9: bit3 shorts receiver link terminations
// R10: bit2 shorts driver link terminations
// R11: bit1 selects ac-coupled receive mode
// R12: channel 5 at 0x49/0x4a, reset zero
// R13: channels 6, 7 at 0x4b..0x4e
// R14: reserved bits stored and read back
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "sync_channel_port_config_consts.vh"

module sync_channel_port_config #(
    parameter DIV_WIDTH = 12,
    parameter ADR_WIDTH = 12
) (
    // clock and reset
    input wire clock,
    input wire reset,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_WIDTH-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // shared divider ratios
    input wire [DIV_WIDTH-1:0] sharedDividerA,
    input wire [DIV_WIDTH-1:0] sharedDividerB,
    // tdc measurement uses receiver, bit 0 is channel 5
    input wire [2:0] tdcUsesReceiver,
    // per channel driver controls, bit 0 is channel 5
    output reg [2:0] dividerChoice,
    output reg [3*DIV_WIDTH-1:0] channelDivideFactor,
    output reg [2:0] driveCurrentHigh,
    output reg [17:0] commonModeResistorCode,
    // per channel receiver and termination controls
    output reg [2:0] receiverAutoPowerdown,
    output reg [2:0] receiverPowered,
    output reg [2:0] receiverGroundDisconnect,
    output reg [2:0] driverGroundDisconnect,
    output reg [2:0] receiverTerminationShort,
    output reg [2:0] driverTerminationShort,
    output reg [2:0] receiveAcCoupling
);

    reg [7:0] drvCfg0_q;
    reg [7:0] drvCfg1_q;
    reg [7:0] drvCfg2_q;
    reg [7:0] rxCfg0_q;
    reg [7:0] rxCfg1_q;
    reg [7:0] rxCfg2_q;
    reg ack_d;
    reg [31:0] readData_d;
    wire request;
    wire wordAligned;
    wire [7:0] regIndex;
    wire writeLane;
    wire [2:0] dividerChoice_d;
    wire [3*DIV_WIDTH-1:0] channelDivideFactor_d;
    wire [2:0] driveCurrentHigh_d;
    wire [17:0] commonModeResistorCode_d;
    wire [2:0] receiverAutoPowerdown_d;
    wire [2:0] receiverPowered_d;
    wire [2:0] receiverGroundDisconnect_d;
    wire [2:0] driverGroundDisconnect_d;
    wire [2:0] receiverTerminationShort_d;
    wire [2:0] driverTerminationShort_d;
    wire [2:0] receiveAcCoupling_d;

    assign request = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wordAligned = (wb_adr_i[1:0] == 2'h0)
        & (wb_adr_i[ADR_WIDTH-1:10] == {(ADR_WIDTH-10){1'b0}});
    assign regIndex = wb_adr_i[9:2];
    // write lands at the edge the master samples ack
    assign writeLane = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];

    // read mux, unmapped reads zero
    always @* begin
        ack_d = request;
        readData_d = 32'h00000000;
        if (!wordAligned) begin
            readData_d = 32'h00000000;
        end else if (regIndex == `CHAN5_DIVIDER_DRIVER_IDX) begin
            readData_d = {24'h000000, drvCfg0_q};
        end else if (regIndex == `CHAN5_RECEIVER_TERM_IDX) begin
            readData_d = {24'h000000, rxCfg0_q};
        end else if (regIndex == `CHAN6_DIVIDER_DRIVER_IDX) begin
            readData_d = {24'h000000, drvCfg1_q};
        end else if (regIndex == `CHAN6_RECEIVER_TERM_IDX) begin
            readData_d = {24'h000000, rxCfg1_q};
        end else if (regIndex == `CHAN7_DIVIDER_DRIVER_IDX) begin
            readData_d = {24'h000000, drvCfg2_q};
        end else if (regIndex == `CHAN7_RECEIVER_TERM_IDX) begin
            readData_d = {24'h000000, rxCfg2_q};
        end
    end

    // bus answer, one cycle after request
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= ack_d;
            if (ack_d && !wb_we_i) begin
                wb_dat_o <= readData_d;
            end
        end
    end

    // R12: channel 5 pair, zero reset
    // R14: whole byte kept incl reserved
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            drvCfg0_q <= `DIVIDER_DRIVER_RESET;
            rxCfg0_q <= `RECEIVER_TERM_RESET;
        end else if (writeLane && wordAligned) begin
            if (regIndex == `CHAN5_DIVIDER_DRIVER_IDX) begin
                drvCfg0_q <= wb_dat_i[7:0];
            end else if (regIndex == `CHAN5_RECEIVER_TERM_IDX) begin
                rxCfg0_q <= wb_dat_i[7:0];
            end
        end
    end

    // R13: channel 6 and 7 pairs
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            drvCfg1_q <= `DIVIDER_DRIVER_RESET;
            rxCfg1_q <= `RECEIVER_TERM_RESET;
            drvCfg2_q <= `DIVIDER_DRIVER_RESET;
            rxCfg2_q <= `RECEIVER_TERM_RESET;
        end else if (writeLane && wordAligned) begin
            if (regIndex == `CHAN6_DIVIDER_DRIVER_IDX) begin
                drvCfg1_q <= wb_dat_i[7:0];
            end else if (regIndex == `CHAN6_RECEIVER_TERM_IDX) begin
                rxCfg1_q <= wb_dat_i[7:0];
            end else if (regIndex == `CHAN7_DIVIDER_DRIVER_IDX) begin
                drvCfg2_q <= wb_dat_i[7:0];
            end else if (regIndex == `CHAN7_RECEIVER_TERM_IDX) begin
                rxCfg2_q <= wb_dat_i[7:0];
            end
        end
    end

    // field decode, channel 5
    sync_channel_field_decode #(
        .DIV_WIDTH(DIV_WIDTH)
    ) i_field5 (
        .driverCfg(drvCfg0_q),
        .receiverCfg(rxCfg0_q),
        .sharedDividerA(sharedDividerA),
        .sharedDividerB(sharedDividerB),
        .tdcUsesReceiver(tdcUsesReceiver[0]),
        .dividerChoice(dividerChoice_d[0]),
        .channelDivideFactor(channelDivideFactor_d[DIV_WIDTH-1:0]),
        .driveCurrentHigh(driveCurrentHigh_d[0]),
        .commonModeResistorCode(commonModeResistorCode_d[5:0]),
        .receiverAutoPowerdown(receiverAutoPowerdown_d[0]),
        .receiverPowered(receiverPowered_d[0]),
        .receiverGroundDisconnect(receiverGroundDisconnect_d[0]),
        .driverGroundDisconnect(driverGroundDisconnect_d[0]),
        .receiverTerminationShort(receiverTerminationShort_d[0]),
        .driverTerminationShort(driverTerminationShort_d[0]),
        .receiveAcCoupling(receiveAcCoupling_d[0])
    );

    // field decode, channel 6
    sync_channel_field_decode #(
        .DIV_WIDTH(DIV_WIDTH)
    ) i_field6 (
        .driverCfg(drvCfg1_q),
        .receiverCfg(rxCfg1_q),
        .sharedDividerA(sharedDividerA),
        .sharedDividerB(sharedDividerB),
        .tdcUsesReceiver(tdcUsesReceiver[1]),
        .dividerChoice(dividerChoice_d[1]),
        .channelDivideFactor(channelDivideFactor_d[2*DIV_WIDTH-1:DIV_WIDTH]),
        .driveCurrentHigh(driveCurrentHigh_d[1]),
        .commonModeResistorCode(commonModeResistorCode_d[11:6]),
        .receiverAutoPowerdown(receiverAutoPowerdown_d[1]),
        .receiverPowered(receiverPowered_d[1]),
        .receiverGroundDisconnect(receiverGroundDisconnect_d[1]),
        .driverGroundDisconnect(driverGroundDisconnect_d[1]),
        .receiverTerminationShort(receiverTerminationShort_d[1]),
        .driverTerminationShort(driverTerminationShort_d[1]),
        .receiveAcCoupling(receiveAcCoupling_d[1])
    );

    // field decode, channel 7
    sync_channel_field_decode #(
        .DIV_WIDTH(DIV_WIDTH)
    ) i_field7 (
        .driverCfg(drvCfg2_q),
        .receiverCfg(rxCfg2_q),
        .sharedDividerA(sharedDividerA),
        .sharedDividerB(sharedDividerB),
        .tdcUsesReceiver(tdcUsesReceiver[2]),
        .dividerChoice(dividerChoice_d[2]),
        .channelDivideFactor(channelDivideFactor_d[3*DIV_WIDTH-1:2*DIV_WIDTH]),
        .driveCurrentHigh(driveCurrentHigh_d[2]),
        .commonModeResistorCode(commonModeResistorCode_d[17:12]),
        .receiverAutoPowerdown(receiverAutoPowerdown_d[2]),
        .receiverPowered(receiverPowered_d[2]),
        .receiverGroundDisconnect(receiverGroundDisconnect_d[2]),
        .driverGroundDisconnect(driverGroundDisconnect_d[2]),
        .receiverTerminationShort(receiverTerminationShort_d[2]),
        .driverTerminationShort(driverTerminationShort_d[2]),
        .receiveAcCoupling(receiveAcCoupling_d[2])
    );

    // registered field outputs per channel
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            dividerChoice <= 3'h0;
            channelDivideFactor <= {3*DIV_WIDTH{1'b0}};
            driveCurrentHigh <= 3'h0;
            commonModeResistorCode <= 18'h00000;
            receiverAutoPowerdown <= 3'h0;
            receiverPowered <= 3'h7;
            receiverGroundDisconnect <= 3'h0;
            driverGroundDisconnect <= 3'h0;
            receiverTerminationShort <= 3'h0;
            driverTerminationShort <= 3'h0;
            receiveAcCoupling <= 3'h0;
        end else begin
            dividerChoice <= dividerChoice_d;
            channelDivideFactor <= channelDivideFactor_d;
            driveCurrentHigh <= driveCurrentHigh_d;
            commonModeResistorCode <= commonModeResistorCode_d;
            receiverAutoPowerdown <= receiverAutoPowerdown_d;
            receiverPowered <= receiverPowered_d;
            receiverGroundDisconnect <= receiverGroundDisconnect_d;
            driverGroundDisconnect <= driverGroundDisconnect_d;
            receiverTerminationShort <= receiverTerminationShort_d;
            driverTerminationShort <= driverTerminationShort_d;
            receiveAcCoupling <= receiveAcCoupling_d;
        end
    end

endmodule // sync_channel_port_config

// field decode of one channel, combinational
module sync_channel_field_decode #(
    parameter DIV_WIDTH = 12
) (
    // channel configuration bytes
    input wire [7:0] driverCfg,
    input wire [7:0] receiverCfg,
    // shared divider ratios and tdc use
    input wire [DIV_WIDTH-1:0] sharedDividerA,
    input wire [DIV_WIDTH-1:0] sharedDividerB,
    input wire tdcUsesReceiver,
    // decoded driver fields
    output wire dividerChoice,
    output wire [DIV_WIDTH-1:0] channelDivideFactor,
    output wire driveCurrentHigh,
    output wire [5:0] commonModeResistorCode,
    // decoded receiver fields
    output wire receiverAutoPowerdown,
    output wire receiverPowered,
    output wire receiverGroundDisconnect,
    output wire driverGroundDisconnect,
    output wire receiverTerminationShort,
    output wire driverTerminationShort,
    output wire receiveAcCoupling
);

    // R1: divider A when clear, B set
    assign dividerChoice = driverCfg[`DIVIDER_CHOICE_BIT];
    assign channelDivideFactor = dividerChoice ? sharedDividerB : sharedDividerA;
    // R2: drive current level
    // R4: also scales common-mode voltage
    assign driveCurrentHigh = driverCfg[`DRIVE_CURRENT_HIGH_BIT];
    // R3: common-mode resistor code
    assign commonModeResistorCode = driverCfg[`CM_CODE_MSB:`CM_CODE_LSB];
    // R5: power down when tdc idle
    assign receiverAutoPowerdown = receiverCfg[`RX_AUTO_POWERDOWN_BIT];
    assign receiverPowered = ~receiverAutoPowerdown | tdcUsesReceiver;
    // R7: receiver float ground switch
    assign receiverGroundDisconnect = receiverCfg[`RX_GROUND_DISCONNECT_BIT];
    // R8: driver float ground switch
    assign driverGroundDisconnect = receiverCfg[`DRV_GROUND_DISCONNECT_BIT];
    // R9: receiver link short
    assign receiverTerminationShort = receiverCfg[`RX_TERM_SHORT_BIT];
    // R10: driver link short
    assign driverTerminationShort = receiverCfg[`DRV_TERM_SHORT_BIT];
    // R11: ac or dc coupling
    assign receiveAcCoupling = receiverCfg[`RX_AC_COUPLING_BIT];

endmodule // sync_channel_field_decode
`default_nettype wire

// File: sync_channel_port_config_consts.vh
// constants for the sync clock channel port configuration bank
// assumes byte addressing on a 32-bit wishbone bus, one word per register
`ifndef SYNC_CHANNEL_PORT_CONFIG_CONSTS_VH
`define SYNC_CHANNEL_PORT_CONFIG_CONSTS_VH

// register indices, byte address is four times the index
`define CHAN5_DIVIDER_DRIVER_IDX 8'h49
`define CHAN5_RECEIVER_TERM_IDX 8'h4a
`define CHAN6_DIVIDER_DRIVER_IDX 8'h4b
`define CHAN6_RECEIVER_TERM_IDX 8'h4c
`define CHAN7_DIVIDER_DRIVER_IDX 8'h4d
`define CHAN7_RECEIVER_TERM_IDX 8'h4e

// reset values
`define DIVIDER_DRIVER_RESET 8'h00
`define RECEIVER_TERM_RESET 8'h00

// first register fields
`define DIVIDER_CHOICE_BIT 7
`define DRIVE_CURRENT_HIGH_BIT 6
`define CM_CODE_MSB 5
`define CM_CODE_LSB 0

// second register fields
`define RX_AUTO_POWERDOWN_BIT 7
`define RX_GROUND_DISCONNECT_BIT 5
`define DRV_GROUND_DISCONNECT_BIT 4
`define RX_TERM_SHORT_BIT 3
`define DRV_TERM_SHORT_BIT 2
`define RX_AC_COUPLING_BIT 1

`endif

// File: sync_channel_port_config_props.sv
// assertions on the port configuration bank ports
// assumes one clock domain and binding to every instance of the bank
`timescale 1ns/100ps
`default_nettype none
module sync_channel_port_config_props #(parameter DIV_WIDTH = 12, parameter ADR_WIDTH = 12) (
    // bus side
    input wire logic clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    // channel side
    input wire logic [DIV_WIDTH-1:0] sharedDividerA,
    input wire logic [3*DIV_WIDTH-1:0] channelDivideFactor,
    input wire logic [17:0] commonModeResistorCode,
    input wire logic [2:0] tdcUsesReceiver, dividerChoice, driveCurrentHigh, receiverPowered,
    input wire logic [2:0] receiverAutoPowerdown, receiverGroundDisconnect,
    input wire logic [2:0] driverGroundDisconnect, receiverTerminationShort,
    input wire logic [2:0] driverTerminationShort, receiveAcCoupling
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    no_stray_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0) else $error("misaligned read not zero");
    field_hold_a: assert property ($changed({dividerChoice, driveCurrentHigh,
        commonModeResistorCode, receiverAutoPowerdown, receiverGroundDisconnect,
        driverGroundDisconnect, receiverTerminationShort, driverTerminationShort,
        receiveAcCoupling}) |-> $past(wb_ack_o && wb_we_i, 2))
        else $error("field moved without write");
    rx_in_use_a: assert property (tdcUsesReceiver != 3'h0
        |=> (receiverPowered & $past(tdcUsesReceiver)) == $past(tdcUsesReceiver))
        else $error("receiver off while in use");
    rx_awake_a: assert property (receiverAutoPowerdown == 3'h0
        && $past(receiverAutoPowerdown) == 3'h0 |-> receiverPowered == 3'h7)
        else $error("receiver off without auto powerdown");
    rx_sleep_a: assert property ((receiverAutoPowerdown[0] && !tdcUsesReceiver[0]) [*3]
        |-> !receiverPowered[0]) else $error("idle receiver still powered");
    div_select_a: assert property (!dividerChoice[0] && $stable(dividerChoice[0])
        && $stable(sharedDividerA) && !$past(reset)
        |-> channelDivideFactor[DIV_WIDTH-1:0] == sharedDividerA) else $error("divider A not used");
endmodule // sync_channel_port_config_props
bind sync_channel_port_config sync_channel_port_config_props #(.DIV_WIDTH(DIV_WIDTH),
    .ADR_WIDTH(ADR_WIDTH)) i_props (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .wb_adr_i, .wb_dat_o, .sharedDividerA, .channelDivideFactor, .commonModeResistorCode,
    .tdcUsesReceiver, .dividerChoice, .driveCurrentHigh, .receiverPowered,
    .receiverAutoPowerdown, .receiverGroundDisconnect, .driverGroundDisconnect,
    .receiverTerminationShort, .driverTerminationShort, .receiveAcCoupling);
`default_nettype wire

// File: sync_channel_port_config_tb.sv
// self-checking bench for the port configuration bank
// assumes the bank answers every request with a one-cycle ack
`timescale 1ns/100ps
`default_nettype none
module sync_channel_port_config_tb;
    logic clock = 0, reset = 1, cyc = 0, stb = 0, we = 0;
    logic [11:0] adr = 12'h0, divA = 12'h019, divB = 12'h0a5;
    logic [3:0] sel = 4'h0;
    logic [31:0] datI = 32'h0, datO;
    logic [2:0] time_to_digital_converter = 3'h0, choice, boost, autoPd, powered, rxGnd, txGnd, rxShort, txShort, acCpl;
    logic ack;
    logic [35:0] factor;
    logic [17:0] cmCode;
    logic [7:0] q, fv [3], sv [3];
    int fail_count = 0, comparisons = 0;
    always #5 clock = ~clock;
    sync_channel_port_config i_dut (.clock(clock), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
        .wb_dat_o(datO), .wb_ack_o(ack), .sharedDividerA(divA), .sharedDividerB(divB),
        .tdcUsesReceiver(time_to_digital_converter), .dividerChoice(choice), .channelDivideFactor(factor),
        .driveCurrentHigh(boost), .commonModeResistorCode(cmCode),
        .receiverAutoPowerdown(autoPd), .receiverPowered(powered),
        .receiverGroundDisconnect(rxGnd), .driverGroundDisconnect(txGnd),
        .receiverTerminationShort(rxShort), .driverTerminationShort(txShort),
        .receiveAcCoupling(acCpl));
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s0);
        @(posedge clock);
        {cyc, stb, we, adr, datI, sel} <= {2'b11, w, a, 24'h0, d, 3'h0, s0};
        do @(posedge clock); while (ack !== 1'b1);
        q = datO[7:0];
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic test_reset;
        for (int i = 0; i < 6; i++) begin
            bus(0, 12'h124 + 12'(4 * i), 8'h0, 1);
            chk(q, 8'h00);
        end
        chk({choice, boost, cmCode}, 0);
        chk({autoPd, rxGnd, txGnd, rxShort, txShort, acCpl}, 0);
        chk(factor, {3{divA}});
        chk(powered, 3'h7);
        $display("test reset done");
    endtask
    task automatic test_fields;
        fv = '{8'hbf, 8'h41, 8'h80};
        sv = '{8'hff, 8'h2a, 8'h55};
        for (int i = 0; i < 3; i++) begin
            bus(1, 12'h124 + 12'(8 * i), fv[i], 1);
            bus(1, 12'h128 + 12'(8 * i), sv[i], 1);
        end
        @(negedge clock);
        for (int i = 0; i < 3; i++) begin
            bus(0, 12'h124 + 12'(8 * i), 8'h0, 1);
            chk(q, fv[i]);
            bus(0, 12'h128 + 12'(8 * i), 8'h0, 1);
            chk(q, sv[i]);
            chk({choice[i], boost[i], cmCode[6*i+:6]}, fv[i]);
            chk(factor[12*i+:12], fv[i][7] ? divB : divA);
            chk({autoPd[i], rxGnd[i], txGnd[i], rxShort[i], txShort[i], acCpl[i]},
                {sv[i][7], sv[i][5:1]});
        end
        $display("test fields done");
    endtask
    task automatic test_refused;
        bus(1, 12'h129, 8'h00, 1);
        bus(1, 12'h128, 8'h00, 0);
        bus(0, 12'h128, 8'h0, 1);
        chk(q, sv[0]);
        bus(0, 12'h129, 8'h0, 1);
        chk(q, 8'h00);
        bus(0, 12'h3fc, 8'h0, 1);
        chk(q, 8'h00);
        bus(1, 12'h524, 8'h00, 1);
        bus(0, 12'h124, 8'h0, 1);
        chk(q, fv[0]);
        bus(0, 12'h524, 8'h0, 1);
        chk(q, 8'h00);
        $display("test refused done");
    endtask
    task automatic test_power;
        // software init of auto powerdown and link short, every channel
        for (int i = 0; i < 3; i++) bus(1, 12'h128 + 12'(8 * i), 8'h88, 1);
        repeat (4) @(posedge clock);
        chk(powered, 3'h0);
        chk(rxShort, 3'h7);
        time_to_digital_converter <= 3'h5;
        repeat (3) @(posedge clock);
        chk(powered, 3'h5);
        time_to_digital_converter <= 3'h0;
        bus(1, 12'h128, 8'h08, 1);
        repeat (3) @(posedge clock);
        chk(powered, 3'h1);
        $display("test power done");
    endtask
    task automatic test_rereset;
        reset <= 1;
        repeat (3) @(posedge clock);
        chk({ack, datO}, 0);
        reset <= 0;
        test_reset;
        $display("test rereset done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge clock);
        reset <= 0;
        test_reset;
        test_fields;
        test_refused;
        test_power;
        test_rereset;
        give_verdict;
    end
endmodule // sync_channel_port_config_tb
`default_nettype wire
